// ---- design/asc_pkg.sv ----
package asc_pkg;
    // register byte addresses
    localparam logic [7:0] A_CTRL  = 8'h00;
    localparam logic [7:0] A_START = 8'h04;
    localparam logic [7:0] A_SEQ   = 8'h08;
    localparam logic [7:0] A_STAT  = 8'h0C;
    localparam logic [7:0] A_IE    = 8'h10;
    localparam logic [7:0] A_THR   = 8'h14;
    localparam logic [7:0] A_DR    = 8'h18;
    localparam logic [7:0] A_JDR   = 8'h1C;
    localparam logic [7:0] A_S1DR  = 8'h20;
    localparam logic [7:0] A_S2DR  = 8'h24;
    localparam logic [1:0] A_SMP_HI = 2'h1;
    // control fields
    localparam int C_EN   = 0;
    localparam int C_CONT = 1;
    localparam int C_SCAN = 2;
    localparam int C_LEFT = 3;
    localparam int C_RES  = 4;
    localparam int C_PRE  = 6;
    localparam int C_DMA  = 8;
    localparam int C_AWR  = 9;
    localparam int C_AWJ  = 10;
    localparam int C_AWS  = 11;
    localparam int C_AWCH = 12;
    localparam int C_RTS  = 16;
    localparam int C_RTE  = 19;
    localparam int C_JTS  = 20;
    localparam int C_JTE  = 23;
    localparam int C_MM   = 24;
    // start strobes, sequence fields
    localparam int S_REG  = 0;
    localparam int S_INJ  = 1;
    localparam int S_SL2  = 2;
    localparam int Q_LAST = 0;
    localparam int Q_INJ  = 4;
    localparam int Q_S2   = 8;
    // status flags
    localparam int F_EOC  = 0;
    localparam int F_JEOC = 1;
    localparam int F_AWD  = 2;
    localparam int F_OVR  = 3;
    // masks and reset values
    localparam logic [31:0] M_SEQ    = 32'h0000_0FFF;
    localparam logic [31:0] M_THR    = 32'h0FFF_0FFF;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] THR_RST  = 32'h0FFF_0000;
    // timing and modes
    localparam logic [8:0] SMP_MIN = 9'h004;
    localparam logic [8:0] SMP_MAX = 9'h1E0;
    localparam logic [3:0] RES_MAX = 4'hC;
    localparam logic [3:0] MM_DUAL_LO = 4'h1;
    localparam logic [3:0] MM_DUAL_HI = 4'h6;
    localparam logic [3:0] MM_TRI_LO  = 4'h7;
    localparam logic [3:0] MM_TRI_HI  = 4'hC;

    typedef enum logic [0:0] {ST_IDLE, ST_CONV} asc_state_t;
    typedef enum logic [1:0] {PH_IDLE, PH_SAMP, PH_CONV} asc_phase_t;
endpackage : asc_pkg

// ---- design/asc_core.sv ----
module asc_core (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        tick_i,
    input  wire logic        start_i,
    input  wire logic [8:0]  smp_i,
    input  wire logic [3:0]  bits_i,
    input  wire logic [11:0] data_i,
    output logic             sample_o,
    output logic             done_o,
    output logic [11:0]      result_o
);
    typedef struct packed {
        asc_pkg::asc_phase_t ph;
        logic [8:0]          cnt;
        logic                done;
        logic                samp;
        logic [11:0]         result;
    } asc_core_st_t;

    asc_core_st_t r;
    asc_core_st_t n;

    // a start while busy is dropped; first converter cycle may be short
    always_comb begin
        n = r;
        n.done = 1'b0;
        case (r.ph)
            asc_pkg::PH_IDLE: begin
                if (start_i) begin
                    n.ph  = asc_pkg::PH_SAMP;
                    n.cnt = smp_i;
                end
            end
            asc_pkg::PH_SAMP: begin
                if (tick_i) begin
                    if (r.cnt == 9'h001) begin
                        n.ph  = asc_pkg::PH_CONV;
                        n.cnt = {5'h00, bits_i};
                    end else begin
                        n.cnt = r.cnt - 9'h001;
                    end
                end
            end
            asc_pkg::PH_CONV: begin
                if (tick_i) begin
                    if (r.cnt == 9'h001) begin
                        n.ph     = asc_pkg::PH_IDLE;
                        n.done   = 1'b1;
                        n.result = data_i;
                    end else begin
                        n.cnt = r.cnt - 9'h001;
                    end
                end
            end
            default: n.ph = asc_pkg::PH_IDLE;
        endcase
        n.samp = (n.ph == asc_pkg::PH_SAMP);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign sample_o = r.samp;
    assign done_o   = r.done;
    assign result_o = r.result;
endmodule : asc_core

// ---- design/asc_top.sv ----
// The Wishbone interface to the registers and the placing of the registers were decided locally.
module asc_top (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic [7:0]  trig_i,
    input  wire logic [11:0] m_data_i,
    input  wire logic [11:0] s1_data_i,
    input  wire logic [11:0] s2_data_i,
    input  wire logic        dma_ack_i,
    output logic             m_sample_o,
    output logic             s1_sample_o,
    output logic             s2_sample_o,
    output logic      [3:0]  chan_o,
    output logic      [3:0]  s2_chan_o,
    output logic             dma_req_o,
    output logic             irq_o
);
    typedef struct packed {
        logic             ack;
        logic [31:0]      dat;
        logic [31:0]      ctrl;
        logic [31:0]      seq;
        logic [3:0]       ie;
        logic [31:0]      thr;
        logic [3:0]       flags;
        logic [15:0]      dr;
        logic [15:0]      jdr;
        logic [15:0]      s1dr;
        logic [15:0]      s2dr;
        logic [15:0][8:0] smp;
        logic [2:0]       pcnt;
        logic             tick;
        logic [7:0]       trig_q;
        asc_pkg::asc_state_t state;
        logic [3:0]       chan;
        logic [3:0]       chan_out;
        logic [3:0]       s2_chan;
        logic             reg_act;
        logic             inj_pend;
        logic             cur_inj;
        logic             unread;
        logic             dma;
        logic             irq;
        logic             mstart;
        logic             s1start;
        logic             s2start;
    } asc_regs_t;

    asc_regs_t r;
    asc_regs_t n;

    logic        en;
    logic        cont;
    logic        scan;
    logic        left;
    logic        dma_en;
    logic        awr;
    logic        awj;
    logic        aws;
    logic [1:0]  res;
    logic [1:0]  pre;
    logic [3:0]  awch;
    logic [2:0]  rts;
    logic [2:0]  jts;
    logic        rte;
    logic        jte;
    logic [3:0]  mm;
    logic [3:0]  last;
    logic [3:0]  injch;
    logic [3:0]  s2ch;
    logic [3:0]  bits;
    logic [11:0] thr_lo;
    logic [11:0] thr_hi;
    logic        dual;
    logic        tri3;
    logic        simul;
    logic        wr;
    logic        rd;
    logic        m_done;
    logic        s1_done;
    logic        s2_done;
    logic [11:0] m_res;
    logic [11:0] s1_res;
    logic [11:0] s2_res;

    assign en     = r.ctrl[asc_pkg::C_EN];
    assign cont   = r.ctrl[asc_pkg::C_CONT];
    assign scan   = r.ctrl[asc_pkg::C_SCAN];
    assign left   = r.ctrl[asc_pkg::C_LEFT];
    assign res    = r.ctrl[asc_pkg::C_RES +: 2];
    assign pre    = r.ctrl[asc_pkg::C_PRE +: 2];
    assign dma_en = r.ctrl[asc_pkg::C_DMA];
    assign awr    = r.ctrl[asc_pkg::C_AWR];
    assign awj    = r.ctrl[asc_pkg::C_AWJ];
    assign aws    = r.ctrl[asc_pkg::C_AWS];
    assign awch   = r.ctrl[asc_pkg::C_AWCH +: 4];
    assign rts    = r.ctrl[asc_pkg::C_RTS +: 3];
    assign rte    = r.ctrl[asc_pkg::C_RTE];
    assign jts    = r.ctrl[asc_pkg::C_JTS +: 3];
    assign jte    = r.ctrl[asc_pkg::C_JTE];
    assign mm     = r.ctrl[asc_pkg::C_MM +: 4];
    assign last   = r.seq[asc_pkg::Q_LAST +: 4];
    assign injch  = r.seq[asc_pkg::Q_INJ +: 4];
    assign s2ch   = r.seq[asc_pkg::Q_S2 +: 4];
    assign thr_lo = r.thr[11:0];
    assign thr_hi = r.thr[27:16];
    assign bits   = asc_pkg::RES_MAX - {1'b0, res, 1'b0};
    assign dual   = (mm >= asc_pkg::MM_DUAL_LO) && (mm <= asc_pkg::MM_DUAL_HI);
    assign tri3   = (mm >= asc_pkg::MM_TRI_LO) && (mm <= asc_pkg::MM_TRI_HI);
    assign simul  = mm[0];
    assign wr     = wb_cyc_i & wb_stb_i & r.ack & wb_we_i;
    assign rd     = wb_cyc_i & wb_stb_i & r.ack & ~wb_we_i;

    function automatic logic [31:0] asc_merge(input logic [31:0] o, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] v;
        v = o;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                v[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return v;
    endfunction : asc_merge

    // lower resolutions drop the low bits of the front end word
    function automatic logic [15:0] asc_align(input logic [11:0] d, input logic [1:0] rs, input logic lf);
        logic [15:0] v;
        v = {4'h0, d} >> {rs, 1'b0};
        if (lf) begin
            v = v << ({1'b0, rs, 1'b0} + 4'h4);
        end
        return v;
    endfunction : asc_align

    function automatic logic [8:0] asc_clamp(input logic [8:0] s);
        logic [8:0] v;
        v = s;
        if (s < asc_pkg::SMP_MIN) begin
            v = asc_pkg::SMP_MIN;
        end else if (s > asc_pkg::SMP_MAX) begin
            v = asc_pkg::SMP_MAX;
        end
        return v;
    endfunction : asc_clamp

    always_comb begin
        logic [3:0]  clr;
        logic [3:0]  set;
        logic [31:0] wv;
        logic        rd_dr;
        logic        hit;
        clr   = 4'h0;
        set   = 4'h0;
        wv    = 32'h0000_0000;
        rd_dr = rd && (wb_adr_i == asc_pkg::A_DR);
        hit   = 1'b0;
        n = r;
        n.mstart  = 1'b0;
        n.s1start = 1'b0;
        n.s2start = 1'b0;

        // bus answer one cycle after the request
        n.ack = wb_cyc_i & wb_stb_i & ~r.ack;
        n.dat = 32'h0000_0000;
        if (n.ack && !wb_we_i) begin
            if (wb_adr_i[7:6] == asc_pkg::A_SMP_HI) begin
                n.dat = {23'h00_0000, r.smp[wb_adr_i[5:2]]};
            end else begin
                case (wb_adr_i)
                    asc_pkg::A_CTRL: n.dat = r.ctrl;
                    asc_pkg::A_SEQ:  n.dat = r.seq;
                    asc_pkg::A_STAT: n.dat = {27'h000_0000, r.reg_act | (r.state == asc_pkg::ST_CONV), r.flags};
                    asc_pkg::A_IE:   n.dat = {28'h000_0000, r.ie};
                    asc_pkg::A_THR:  n.dat = r.thr;
                    asc_pkg::A_DR:   n.dat = {16'h0000, r.dr};
                    asc_pkg::A_JDR:  n.dat = {16'h0000, r.jdr};
                    asc_pkg::A_S1DR: n.dat = {16'h0000, r.s1dr};
                    asc_pkg::A_S2DR: n.dat = {16'h0000, r.s2dr};
                    default:         n.dat = 32'h0000_0000;
                endcase
            end
        end

        // converter clock prescaler
        n.tick = 1'b0;
        if (r.pcnt == {pre, 1'b1}) begin
            n.pcnt = 3'h0;
            n.tick = 1'b1;
        end else begin
            n.pcnt = r.pcnt + 3'h1;
        end

        // register writes take effect on the acked edge
        if (wr) begin
            if (wb_adr_i[7:6] == asc_pkg::A_SMP_HI) begin
                wv = asc_merge({23'h00_0000, r.smp[wb_adr_i[5:2]]}, wb_dat_i, wb_sel_i);
                n.smp[wb_adr_i[5:2]] = asc_clamp(wv[8:0]);
            end else begin
                case (wb_adr_i)
                    asc_pkg::A_CTRL: n.ctrl = asc_merge(r.ctrl, wb_dat_i, wb_sel_i);
                    asc_pkg::A_SEQ:  n.seq = asc_merge(r.seq, wb_dat_i, wb_sel_i) & asc_pkg::M_SEQ;
                    asc_pkg::A_IE: begin
                        wv   = asc_merge({28'h000_0000, r.ie}, wb_dat_i, wb_sel_i);
                        n.ie = wv[3:0];
                    end
                    asc_pkg::A_THR:  n.thr = asc_merge(r.thr, wb_dat_i, wb_sel_i) & asc_pkg::M_THR;
                    asc_pkg::A_STAT: clr = wb_sel_i[0] ? wb_dat_i[3:0] : 4'h0;
                    asc_pkg::A_START: begin
                        if (wb_sel_i[0] && wb_dat_i[asc_pkg::S_REG] && en && !r.reg_act) begin
                            n.reg_act = 1'b1;
                            n.chan    = scan ? 4'h0 : last;
                        end
                        if (wb_sel_i[0] && wb_dat_i[asc_pkg::S_INJ] && en) begin
                            n.inj_pend = 1'b1;
                        end
                        if (wb_sel_i[0] && wb_dat_i[asc_pkg::S_SL2] && !tri3) begin
                            n.s2start = 1'b1;
                            n.s2_chan = s2ch;
                        end
                    end
                    default: n.ctrl = r.ctrl;
                endcase
            end
        end

        // external triggers, rising edge of the selected line
        n.trig_q = trig_i;
        if (en && rte && trig_i[rts] && !r.trig_q[rts] && !n.reg_act) begin
            n.reg_act = 1'b1;
            n.chan    = scan ? 4'h0 : last;
        end
        if (en && jte && trig_i[jts] && !r.trig_q[jts]) begin
            n.inj_pend = 1'b1;
        end

        // reading the data word or a data transfer ack consumes it
        if (rd_dr || dma_ack_i) begin
            n.unread = 1'b0;
            n.dma    = 1'b0;
        end
        if (rd_dr) begin
            clr[asc_pkg::F_EOC] = 1'b1;
        end
        if (wr && wb_adr_i == asc_pkg::A_JDR) begin
            clr[asc_pkg::F_JEOC] = 1'b0;
        end

        // master result handling
        if (m_done) begin
            hit = (!aws || r.chan_out == awch) && (r.cur_inj ? awj : awr);
            if (hit && (m_res < thr_lo || m_res > thr_hi)) begin
                set[asc_pkg::F_AWD] = 1'b1;
            end
            if (r.cur_inj) begin
                n.jdr = asc_align(m_res, res, left);
                set[asc_pkg::F_JEOC] = 1'b1;
            end else begin
                n.dr = asc_align(m_res, res, left);
                set[asc_pkg::F_EOC] = 1'b1;
                if (r.unread && !rd_dr && !dma_ack_i) begin
                    set[asc_pkg::F_OVR] = 1'b1;
                end
                n.unread = 1'b1;
                n.dma    = dma_en;
                if (scan && r.chan < last) begin
                    n.chan = r.chan + 4'h1;
                end else begin
                    n.chan = scan ? 4'h0 : last;
                    if (!cont) begin
                        n.reg_act = 1'b0;
                    end
                end
            end
        end

        // slave results and alternate chaining
        if (s1_done) begin
            n.s1dr = asc_align(s1_res, res, left);
        end
        if (s2_done) begin
            n.s2dr = asc_align(s2_res, res, left);
        end
        if ((dual || tri3) && !simul && m_done) begin
            n.s1start = 1'b1;
        end
        if (tri3 && !simul && s1_done) begin
            n.s2start = 1'b1;
            n.s2_chan = r.chan_out;
        end

        // launch: injected first, then the regular sequence
        if (!en) begin
            n.reg_act  = 1'b0;
            n.inj_pend = 1'b0;
        end
        if (r.state == asc_pkg::ST_IDLE || m_done) begin
            n.state = asc_pkg::ST_IDLE;
            if (n.inj_pend) begin
                n.inj_pend = 1'b0;
                n.cur_inj  = 1'b1;
                n.chan_out = injch;
                n.mstart   = 1'b1;
                n.state    = asc_pkg::ST_CONV;
            end else if (n.reg_act) begin
                n.cur_inj  = 1'b0;
                n.chan_out = n.chan;
                n.mstart   = 1'b1;
                n.state    = asc_pkg::ST_CONV;
            end
            if (n.mstart && (dual || tri3) && simul) begin
                n.s1start = 1'b1;
            end
            if (n.mstart && tri3 && simul) begin
                n.s2start = 1'b1;
                n.s2_chan = n.chan_out;
            end
        end

        // set wins over a same-cycle clear
        n.flags = (r.flags & ~clr) | set;
        n.irq   = |(n.flags & n.ie);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r        <= '0;
            r.ctrl   <= asc_pkg::CTRL_RST;
            r.thr    <= asc_pkg::THR_RST;
            r.smp    <= {16{asc_pkg::SMP_MIN}};
        end else begin
            r <= n;
        end
    end

    asc_core u_master (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .tick_i   (r.tick),
        .start_i  (r.mstart),
        .smp_i    (r.smp[r.chan_out]),
        .bits_i   (bits),
        .data_i   (m_data_i),
        .sample_o (m_sample_o),
        .done_o   (m_done),
        .result_o (m_res)
    );

    asc_core u_slave1 (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .tick_i   (r.tick),
        .start_i  (r.s1start),
        .smp_i    (r.smp[r.chan_out]),
        .bits_i   (bits),
        .data_i   (s1_data_i),
        .sample_o (s1_sample_o),
        .done_o   (s1_done),
        .result_o (s1_res)
    );

    asc_core u_slave2 (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .tick_i   (r.tick),
        .start_i  (r.s2start),
        .smp_i    (r.smp[r.s2_chan]),
        .bits_i   (bits),
        .data_i   (s2_data_i),
        .sample_o (s2_sample_o),
        .done_o   (s2_done),
        .result_o (s2_res)
    );

    assign wb_dat_o  = r.dat;
    assign wb_ack_o  = r.ack;
    assign chan_o    = r.chan_out;
    assign s2_chan_o = r.s2_chan;
    assign dma_req_o = r.dma;
    assign irq_o     = r.irq;
endmodule : asc_top

// ---- verif/asc_fe_model.sv ----
module asc_fe_model (
    input  wire logic        m_sample_i,
    input  wire logic        s1_sample_i,
    input  wire logic        s2_sample_i,
    input  wire logic [3:0]  chan_i,
    input  wire logic [3:0]  s2_chan_i,
    output wire logic [11:0] m_data_o,
    output wire logic [11:0] s1_data_o,
    output wire logic [11:0] s2_data_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] mc_r = 4'h0;
    logic [3:0] c1_r = 4'h0;
    logic [3:0] c2_r = 4'h0;
    // channel held from the sampling window
    always @* if (m_sample_i) mc_r = chan_i;
    always @* if (s1_sample_i) c1_r = chan_i;
    always @* if (s2_sample_i) c2_r = s2_chan_i;
    // inverted while the hold is open: level not settled yet
    assign m_data_o  = {8'hA5, mc_r} ^ {12{m_sample_i}};
    assign s1_data_o = {8'h3C, c1_r} ^ {12{s1_sample_i}};
    assign s2_data_o = {8'hC3, c2_r} ^ {12{s2_sample_i}};
endmodule : asc_fe_model

// ---- verif/asc_top_sva.sv ----
module asc_top_sva (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        dma_ack_i,
    input wire logic        m_sample_o,
    input wire logic [3:0]  chan_o,
    input wire logic        dma_req_o
);
    default clocking dc @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    logic        req;
    logic        dr_rd;
    logic [11:0] scnt_r;
    assign req = wb_cyc_i && wb_stb_i;
    assign dr_rd = wb_ack_o && !wb_we_i && wb_adr_i == asc_pkg::A_DR;
    // longest sampling: 480 ticks of the slowest divider
    always_ff @(posedge clk_i) scnt_r <= (rst_i || !m_sample_o) ? 12'h000 : scnt_r + 12'h001;
    property p_ack_resp;
        req && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack_resp: assert property (p_ack_resp) else $error("no ack one cycle after request");
    property p_ack_idle;
        !req |=> !wb_ack_o;
    endproperty
    a_ack_idle: assert property (p_ack_idle) else $error("ack without request");
    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    property p_rd_zero;
        wb_ack_o && !wb_we_i && (wb_adr_i == asc_pkg::A_START || wb_adr_i == 8'hFC) |-> wb_dat_o == 32'h0000_0000;
    endproperty
    a_rd_zero: assert property (p_rd_zero) else $error("write-only or unmapped read not zero");
    property p_dma_hold;
        dma_req_o && !dma_ack_i && !dr_rd |=> dma_req_o;
    endproperty
    a_dma_hold: assert property (p_dma_hold) else $error("data request dropped unserviced");
    property p_dma_late;
        $rose(dma_req_o) |-> !$past(m_sample_o, 8);
    endproperty
    a_dma_late: assert property (p_dma_late) else $error("result before conversion phase");
    property p_smp_min;
        $rose(m_sample_o) |-> m_sample_o [*6];
    endproperty
    a_smp_min: assert property (p_smp_min) else $error("sampling shorter than minimum");
    property p_smp_max;
        scnt_r <= 12'hF08;
    endproperty
    a_smp_max: assert property (p_smp_max) else $error("sampling longer than maximum");
    property p_chan_hold;
        m_sample_o ##1 m_sample_o |-> $stable(chan_o);
    endproperty
    a_chan_hold: assert property (p_chan_hold) else $error("channel changed while sampling");
endmodule : asc_top_sva

bind asc_top asc_top_sva asc_top_sva_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .dma_ack_i(dma_ack_i),
    .m_sample_o(m_sample_o), .chan_o(chan_o), .dma_req_o(dma_req_o));

// ---- verif/testbench.sv ----
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, dma_ack_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00, trig_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, q;
    logic [11:0] m_data_i, s1_data_i, s2_data_i;
    logic        wb_ack_o, m_sample_o, s1_sample_o, s2_sample_o, dma_req_o, irq_o, pm, p1, p2;
    logic [3:0]  chan_o, s2_chan_o;
    logic [3:0]  chq[$];
    int          fails = 0, checks_done = 0, mcnt = 0, s1cnt = 0, s2cnt = 0, n, lo, hi;

    always #50 clk_i = ~clk_i;

    asc_top asc_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .trig_i(trig_i), .m_data_i(m_data_i), .s1_data_i(s1_data_i), .s2_data_i(s2_data_i),
        .dma_ack_i(dma_ack_i), .m_sample_o(m_sample_o), .s1_sample_o(s1_sample_o), .s2_sample_o(s2_sample_o),
        .chan_o(chan_o), .s2_chan_o(s2_chan_o), .dma_req_o(dma_req_o), .irq_o(irq_o));
    asc_fe_model asc_fe_model_i (.m_sample_i(m_sample_o), .s1_sample_i(s1_sample_o), .s2_sample_i(s2_sample_o),
        .chan_i(chan_o), .s2_chan_i(s2_chan_o), .m_data_o(m_data_i), .s1_data_o(s1_data_i), .s2_data_o(s2_data_i));

    always @(posedge clk_i) begin
        if (m_sample_o === 1'b1 && pm !== 1'b1) begin
            mcnt++;
            chq.push_back(chan_o);
        end
        s1cnt += (s1_sample_o === 1'b1 && p1 !== 1'b1);
        s2cnt += (s2_sample_o === 1'b1 && p2 !== 1'b1);
        pm = m_sample_o;
        p1 = s1_sample_o;
        p2 = s2_sample_o;
    end

    task automatic final_report;
        $display("checks %0d errors %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : final_report

    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            fails++;
            $display("ERROR %s exp %h got %h", nm, e, g);
        end
    endtask : cmp

    task automatic tk(input int c);
        repeat (c) @(posedge clk_i);
    endtask : tk

    task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge clk_i);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 20);
        q = wb_dat_o;
        if (wb_ack_o !== 1'b1) fails++;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0000_0000);
        cmp($sformatf("reg %h", a), e, q);
    endtask : rd

    // start a regular pass, wait for its data request
    task automatic conv(input logic [31:0] c);
        wr(asc_pkg::A_CTRL, c);
        wr(asc_pkg::A_START, 32'h0000_0001);
        n = 0;
        while (dma_req_o !== 1'b1 && n < 4000) begin
            @(posedge clk_i);
            n++;
        end
    endtask : conv

    initial begin
        tk(20000);
        fails++;
        final_report;
    end

    initial begin
        tk(2);
        rst_i <= 1'b0;
        rd(asc_pkg::A_CTRL, asc_pkg::CTRL_RST);
        rd(asc_pkg::A_THR, asc_pkg::THR_RST);
        rd(8'h40, 32'h0000_0004);
        rd(asc_pkg::A_STAT, 32'h0000_0000);
        rd(asc_pkg::A_START, 32'h0000_0000);
        rd(8'hFC, 32'h0000_0000);
        wr(8'h44, 32'h0000_0000);
        rd(8'h44, 32'h0000_0004);
        wr(8'h44, 32'h0000_FFFF);
        rd(8'h44, 32'h0000_01E0);
        wr(asc_pkg::A_THR, 32'hFFFF_FFFF);
        rd(asc_pkg::A_THR, asc_pkg::M_THR);
        for (int i = 0; i < 7; i++) begin
            lo = (i < 4) ? i : 0;
            hi = (i < 4) ? 0 : i - 3;
            conv(32'h0000_0101 | lo << 4 | hi << 6 | (i > 3 ? 8 : 0));
            cmp("conv time", 1, n >= (15 - 2 * lo) * (2 + 2 * hi) + 1 && n <= (16 - 2 * lo) * (2 + 2 * hi) + 4);
            rd(asc_pkg::A_DR, i > 3 ? 32'h0000_A500 : 32'h0000_0A50 >> 2 * lo);
            cmp("dma req", 0, dma_req_o);
        end
        conv(32'h0000_0139);
        dma_ack_i <= 1'b1;
        tk(1);
        dma_ack_i <= 1'b0;
        tk(1);
        cmp("dma req", 0, dma_req_o);
        rd(asc_pkg::A_DR, 32'h0000_A400);
        mcnt = 0;
        conv(32'h0000_0101);
        wr(asc_pkg::A_START, 32'h0000_0001);
        tk(60);
        cmp("starts", 2, mcnt);
        rd(asc_pkg::A_STAT, 32'h0000_0009);
        wr(asc_pkg::A_STAT, 32'h0000_000F);
        xfer(1'b0, asc_pkg::A_DR, 32'h0000_0000);
        rd(asc_pkg::A_STAT, 32'h0000_0000);
        wr(asc_pkg::A_THR, 32'h0100_0000);
        wr(asc_pkg::A_IE, 32'h0000_0004);
        for (int i = 0; i < 3; i++) begin
            conv(i == 0 ? 32'h0000_0B01 : i == 1 ? 32'h0000_3B01 : 32'h0000_0501);
            rd(asc_pkg::A_STAT, i == 0 ? 32'h0000_0005 : 32'h0000_0001);
            cmp("irq", i == 0, irq_o);
            wr(asc_pkg::A_STAT, 32'h0000_000F);
            xfer(1'b0, asc_pkg::A_DR, 32'h0000_0000);
            cmp("irq", 0, irq_o);
        end
        wr(asc_pkg::A_SEQ, 32'h0000_0002);
        chq.delete();
        conv(32'h0000_0105);
        tk(1200);
        cmp("scan count", 3, chq.size());
        for (int i = 0; i < 3; i++) cmp("scan chan", i, chq[i]);
        rd(asc_pkg::A_DR, 32'h0000_0A52);
        wr(asc_pkg::A_STAT, 32'h0000_000F);
        wr(asc_pkg::A_SEQ, 32'h0000_0000);
        mcnt = 0;
        conv(32'h0000_0103);
        tk(150);
        wr(asc_pkg::A_CTRL, 32'h0000_0101);
        tk(60);
        lo = mcnt;
        cmp("continuous", 1, lo >= 4);
        tk(100);
        cmp("stopped", lo, mcnt);
        xfer(1'b0, asc_pkg::A_DR, 32'h0000_0000);
        wr(asc_pkg::A_STAT, 32'h0000_000F);
        wr(asc_pkg::A_SEQ, 32'h0000_0050);
        wr(asc_pkg::A_CTRL, 32'h00B9_0101);
        trig_i <= 8'h02;
        tk(2);
        trig_i <= 8'h00;
        tk(100);
        rd(asc_pkg::A_DR, 32'h0000_0A50);
        trig_i <= 8'h08;
        tk(2);
        trig_i <= 8'h00;
        tk(60);
        rd(asc_pkg::A_STAT, 32'h0000_0002);
        rd(asc_pkg::A_JDR, 32'h0000_0A55);
        wr(asc_pkg::A_SEQ, 32'h0000_0000);
        for (int i = 0; i < 4; i++) begin
            lo = (i < 2) ? i + 1 : i + 5;
            s1cnt = 0;
            s2cnt = 0;
            conv(32'h0000_0101 | lo << 24);
            tk(100);
            cmp("slave1", 1, s1cnt);
            cmp("slave2", lo > 6, s2cnt);
            rd(asc_pkg::A_S1DR, 32'h0000_03C0);
            xfer(1'b0, asc_pkg::A_DR, 32'h0000_0000);
        end
        wr(asc_pkg::A_SEQ, 32'h0000_0300);
        wr(asc_pkg::A_CTRL, 32'h0100_0101);
        s2cnt = 0;
        wr(asc_pkg::A_START, 32'h0000_0004);
        tk(60);
        cmp("slave2", 1, s2cnt);
        rd(asc_pkg::A_S2DR, 32'h0000_0C33);
        final_report;
    end
endmodule : testbench
